// *** design/gbi_board.sv ***
`timescale 1ns/10ps
// Function
// [RULE_01] Refresh memory of 6144 bytes shared by video generator and host.
// [RULE_02] Video generator reads bytes over a 13-bit address for display.
// [RULE_03] Video generator releases address and data while bus owns memory.
// [RULE_04] Host A13-A15 match board switch while inactive routes A0-A12.
// [RULE_05] Inactive when field or row pulse low; option uses field alone.
// [RULE_06] Write strobe drives data to memory; read status drives to bus.
// [RULE_07] I/O cycles never reach the refresh memory.
// [RULE_08] Access during active display holds the processor in wait.
// [RULE_09] Guard jumper fitted refuses access unless mode bit 7 set.
// [RULE_10] Output cycle matching port switch latches data into mode latch.
// [RULE_11] Bit 4 picks graphics; bits 0-2 choose graphics mode 0-7.
// [RULE_12] Bits 4 and 5 both low present alphanumeric characters.
// [RULE_13] Bit 5 high gives semigraphics-4 or -6 by bit 6.
// [RULE_14] Bit 3 selects border colour or semigraphic colour set.
// [RULE_15] Bank port decodes at fixed I/O address 40 hex.
// [RULE_16] Matching bank write sets bank flip-flop and lights indicator.
// [RULE_17] Memory access needs bank selected and bus owning memory.
// [RULE_18] Video timing comes from the colour subcarrier clock.
// [RULE_19] Bank enable when any written one meets a closed switch.
// [RULE_20] Power-on clear resets bank latch; jumper adds another clear.
// [RULE_21] Wait jumper adds one wait state to every memory cycle.
// [RULE_22] Bank disable switch keeps the board enabled always.
// [RULE_23] Non-matching bank write clears the bank flip-flop.
module gbi_board
  import gbi_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_power_on_clear_b,
  input wire logic i_ext_clear_b,
  input wire logic i_external_clear_jumper,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_data_out,
  input wire logic i_smemr,
  input wire logic i_mwrt,
  input wire logic i_sout,
  input wire logic i_sinp,
  input wire logic [7:0] i_bank_match_switch,
  input wire logic [7:0] i_port_address_switch,
  input wire logic [2:0] i_board_address_switch,
  input wire logic i_bank_disable_switch,
  input wire logic i_wait_insert_jumper,
  input wire logic i_write_guard_jumper,
  input wire logic i_field_only_option,
  input wire logic i_field_pulse_b,
  input wire logic i_row_restart_pulse_b,
  input wire logic [12:0] i_video_addr,
  output logic o_bus_owns_memory_b,
  output logic [12:0] o_mem_addr,
  output logic o_mem_we,
  output logic [7:0] o_mem_wdata,
  output logic [7:0] o_data_in,
  output logic o_data_in_oe,
  output logic o_ready,
  output logic o_bank_led,
  output logic o_board_led,
  output logic [7:0] o_mode,
  output logic o_color_set_select,
  output logic o_semigraphic_set_select,
  output logic [2:0] o_graphics_mode,
  output logic [2:0] o_disp_kind
);
  logic [7:0] mem [0:REFRESH_BYTES-1];
  logic [15:0] addr_s1_reg, addr_s2_reg;
  logic [7:0] dout_s1_reg, dout_s2_reg;
  logic [3:0] ctl_s1_reg, ctl_s2_reg;
  logic [1:0] sync_s1_reg, sync_s2_reg;
  logic [1:0] clr_s1_reg, clr_s2_reg;
  logic poc_b_s, ext_b_s, bank_clear;
  logic [7:0] mode_reg;
  logic bank_reg;
  logic sout_d_reg;
  gbi_cyc_e cyc_reg;
  logic [1:0] wait_reg;
  logic [7:0] rdata_reg;
  logic [12:0] maddr_reg;
  logic smemr_s, mwrt_s, sout_s, sinp_s, fs_b_s, rp_b_s;
  logic inactive, board_hit, access_ok, mem_cycle, sout_edge, bank_en;
  gbi_disp_e disp;

  // Low address byte compare shared by the mode port and the bank port.
  function automatic logic port_hit(input logic [15:0] addr, input logic [7:0] port);
    return addr[7:0] == port;
  endfunction : port_hit

  // Bus address and data come from the processor's domain.
  always_ff @(posedge i_clock) begin
    addr_s1_reg <= i_addr;
    addr_s2_reg <= addr_s1_reg;
    dout_s1_reg <= i_data_out;
    dout_s2_reg <= dout_s1_reg;
  end

  // Strobes pass the same two stages so they stay aligned with address and data.
  always_ff @(posedge i_clock) begin
    ctl_s1_reg <= {i_smemr, i_mwrt, i_sout, i_sinp};
    ctl_s2_reg <= ctl_s1_reg;
  end

  // Field and row pulses follow the video generator's subcarrier timing, not this clock.
  always_ff @(posedge i_clock) begin
    sync_s1_reg <= {i_field_pulse_b, i_row_restart_pulse_b}; // RULE_18
    sync_s2_reg <= sync_s1_reg;
  end

  // Clear inputs are pins and may change at any time.
  always_ff @(posedge i_clock) begin
    clr_s1_reg <= {i_power_on_clear_b, i_ext_clear_b};
    clr_s2_reg <= clr_s1_reg;
  end

  assign {smemr_s, mwrt_s, sout_s, sinp_s} = ctl_s2_reg;
  assign {fs_b_s, rp_b_s} = sync_s2_reg;
  assign {poc_b_s, ext_b_s} = clr_s2_reg;
  assign bank_clear = !poc_b_s || (i_external_clear_jumper && !ext_b_s); // RULE_20
  // Field pulse alone is slower but keeps the border free of glitches.
  assign inactive = !fs_b_s || (!i_field_only_option && !rp_b_s); // RULE_05
  assign board_hit = addr_s2_reg[15:BOARD_ADDR_LSB] == i_board_address_switch; // RULE_04
  assign bank_en = bank_reg || i_bank_disable_switch; // RULE_22
  assign access_ok = bank_en && (!i_write_guard_jumper || mode_reg[MODE_PROTECT_BIT]); // RULE_09
  // Input and output cycles never open a memory access.
  assign mem_cycle = (smemr_s || mwrt_s) && !sout_s && !sinp_s && board_hit && access_ok; // RULE_07
  assign sout_edge = sout_s && !sout_d_reg;

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      sout_d_reg <= 1'b0;
    end else begin
      sout_d_reg <= sout_s;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mode_reg <= MODE_RESET;
    end else if (sout_edge && port_hit(addr_s2_reg, i_port_address_switch)) begin
      mode_reg <= dout_s2_reg; // RULE_10
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b || bank_clear) begin
      bank_reg <= BANK_RESET; // RULE_20
    end else if (sout_edge && port_hit(addr_s2_reg, BANK_PORT_ADDR[7:0])) begin // RULE_15
      bank_reg <= |(dout_s2_reg & i_bank_match_switch); // RULE_16 RULE_19 RULE_23
    end
  end

  // Host cycle: hold until display inactive, then wait states, then transfer.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cyc_reg <= GBI_IDLE;
      wait_reg <= 2'h0;
      maddr_reg <= 13'h0000;
    end else begin
      case (cyc_reg)
        GBI_IDLE: begin
          if (mem_cycle) begin
            cyc_reg <= GBI_HOLD;
            maddr_reg <= addr_s2_reg[12:0];
            wait_reg <= i_wait_insert_jumper ? WAIT_STATES : 2'h0; // RULE_21
          end
        end
        GBI_HOLD: begin
          if (!mem_cycle) begin
            cyc_reg <= GBI_IDLE;
          end else if (inactive) begin // RULE_08
            if (wait_reg == 2'h0) begin
              cyc_reg <= GBI_XFER;
            end else begin
              wait_reg <= wait_reg - 2'h1;
            end
          end
        end
        GBI_XFER: begin
          if (!mem_cycle) begin
            cyc_reg <= GBI_IDLE;
          end
        end
        default: cyc_reg <= GBI_IDLE;
      endcase
    end
  end

  assign o_bus_owns_memory_b = !(cyc_reg == GBI_XFER && inactive); // RULE_17 RULE_03
  assign o_mem_addr = o_bus_owns_memory_b ? i_video_addr : maddr_reg; // RULE_02 RULE_04
  assign o_mem_we = !o_bus_owns_memory_b && mwrt_s; // RULE_06
  assign o_mem_wdata = dout_s2_reg;
  assign o_ready = !(cyc_reg == GBI_HOLD) && !(cyc_reg == GBI_IDLE && mem_cycle); // RULE_08
  assign o_data_in_oe = cyc_reg == GBI_XFER && smemr_s; // RULE_06
  assign o_data_in = rdata_reg;

  // Shared memory; the video path reads whenever the bus does not own it.
  always_ff @(posedge i_clock) begin
    if (o_mem_we && o_mem_addr < 13'(REFRESH_BYTES)) begin // RULE_01
      mem[o_mem_addr] <= o_mem_wdata;
    end
    rdata_reg <= (o_mem_addr < 13'(REFRESH_BYTES)) ? mem[o_mem_addr] : 8'h00;
  end

  assign o_bank_led = bank_en; // RULE_16
  assign o_board_led = cyc_reg != GBI_IDLE;
  assign o_mode = mode_reg;
  assign o_color_set_select = mode_reg[MODE_COLOR_SET_BIT]; // RULE_14
  assign o_semigraphic_set_select = mode_reg[MODE_SEMI_SET_BIT];
  assign o_graphics_mode = mode_reg[MODE_GM_MSB:MODE_GM_LSB]; // RULE_11

  always_comb begin
    if (mode_reg[MODE_ALPHA_GFX_BIT]) begin
      disp = GBI_DISP_GFX; // RULE_11
    end else if (mode_reg[MODE_ALPHA_SEMI_BIT]) begin
      disp = mode_reg[MODE_SEMI_SET_BIT] ? GBI_DISP_SEMI6 : GBI_DISP_SEMI4; // RULE_13
    end else begin
      disp = GBI_DISP_ALPHA; // RULE_12
    end
  end
  assign o_disp_kind = disp;

  mode_latch_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    sout_edge && addr_s2_reg[7:0] == i_port_address_switch |=> mode_reg == $past(dout_s2_reg))
    else $error("mode latch missed"); // RULE_10
  bank_write_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    sout_edge && port_hit(addr_s2_reg, BANK_PORT_ADDR[7:0]) && !bank_clear
    |=> bank_reg == |($past(dout_s2_reg) & $past(i_bank_match_switch)))
    else $error("bank latch wrong"); // RULE_19
  hold_active_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !inactive |-> o_bus_owns_memory_b) else $error("bus owns memory during display"); // RULE_08
  io_ignore_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && (sout_s || sinp_s) |=> cyc_reg == GBI_IDLE)
    else $error("io reached memory"); // RULE_07
  guard_block_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_write_guard_jumper && !mode_reg[7] |-> !mem_cycle) else $error("guard bypassed"); // RULE_09
  poc_clear_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !poc_b_s |=> !bank_reg) else $error("bank not cleared"); // RULE_20
  write_path_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_mem_we |-> mwrt_s && cyc_reg == GBI_XFER && inactive) else $error("stray write"); // RULE_06
  wait_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && mem_cycle && i_wait_insert_jumper ##1 (inactive && mem_cycle)[*2]
    |=> cyc_reg == GBI_XFER && $past(cyc_reg) == GBI_HOLD) else $error("wait count"); // RULE_21
  disp_mode_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !mode_reg[4] && mode_reg[5] |-> o_disp_kind == {1'b0, mode_reg[6], !mode_reg[6]})
    else $error("semigraphics select"); // RULE_13

  // Display selection from the mode latch, and the latch holding between port writes.
  graphics_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    mode_reg[MODE_ALPHA_GFX_BIT] |-> o_disp_kind == GBI_DISP_GFX && o_graphics_mode == mode_reg[2:0])
    else $error("graphics select"); // RULE_11
  alpha_sel_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !mode_reg[MODE_ALPHA_GFX_BIT] && !mode_reg[MODE_ALPHA_SEMI_BIT] |-> o_disp_kind == GBI_DISP_ALPHA)
    else $error("alpha select"); // RULE_12
  mode_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !(sout_edge && port_hit(addr_s2_reg, i_port_address_switch)) |=> mode_reg == $past(mode_reg))
    else $error("mode changed without write"); // RULE_10

  // Display activity and the processor wait.
  field_only_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    i_field_only_option && fs_b_s |-> !inactive)
    else $error("row pulse used in field-only build"); // RULE_05
  row_inactive_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !i_field_only_option && !rp_b_s |-> inactive)
    else $error("row pulse ignored"); // RULE_05
  ready_hold_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_HOLD |-> !o_ready)
    else $error("ready during hold"); // RULE_08
  xfer_ready_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_XFER |-> o_ready)
    else $error("wait during transfer"); // RULE_08
  ready_idle_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && !mem_cycle |-> o_ready)
    else $error("wait without access"); // RULE_07
  wait_none_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && mem_cycle && !i_wait_insert_jumper ##1 (inactive && mem_cycle)
    |=> cyc_reg == GBI_XFER) else $error("extra wait state"); // RULE_21
  wait_reload_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && mem_cycle |=> wait_reg == ($past(i_wait_insert_jumper) ? WAIT_STATES : 2'h0))
    else $error("wait count load"); // RULE_21

  // Memory ownership and decode gates.
  board_miss_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    cyc_reg == GBI_IDLE && !board_hit |=> cyc_reg == GBI_IDLE)
    else $error("foreign address taken"); // RULE_04
  bank_gate_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !bank_en |-> !mem_cycle)
    else $error("access with bank off"); // RULE_17
  video_path_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_bus_owns_memory_b |-> o_mem_addr == i_video_addr)
    else $error("video address blocked"); // RULE_03
  host_addr_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !o_bus_owns_memory_b |-> o_mem_addr == maddr_reg)
    else $error("host address not routed"); // RULE_04
  read_oe_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    o_data_in_oe |-> smemr_s && cyc_reg == GBI_XFER)
    else $error("stray read drive"); // RULE_06

  // Bank latch decode.
  bank_port_a: assert property (@(posedge i_clock) disable iff (!i_rst_b)
    !(sout_edge && port_hit(addr_s2_reg, BANK_PORT_ADDR[7:0])) && !bank_clear |=> bank_reg == $past(bank_reg))
    else $error("bank changed off its port"); // RULE_15

  read_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_data_in_oe);
  write_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) o_mem_we);
  held_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) cyc_reg == GBI_HOLD && !inactive);
  bank_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) $rose(bank_reg));
  wait_c: cover property (@(posedge i_clock) disable iff (!i_rst_b) cyc_reg == GBI_HOLD && wait_reg != 2'h0);
endmodule : gbi_board

// *** pkg/gbi_pkg.sv ***
package gbi_pkg;
  localparam logic [15:0] BANK_PORT_ADDR = 16'h0040;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam int MODE_PROTECT_BIT = 7;
  localparam int MODE_SEMI_SET_BIT = 6;
  localparam int MODE_ALPHA_SEMI_BIT = 5;
  localparam int MODE_ALPHA_GFX_BIT = 4;
  localparam int MODE_COLOR_SET_BIT = 3;
  localparam int MODE_GM_LSB = 0;
  localparam int MODE_GM_MSB = 2;
  localparam logic BANK_RESET = 1'b0;
  localparam int REFRESH_BYTES = 6144;
  localparam int VID_ADDR_W = 13;
  localparam int BOARD_ADDR_LSB = 13;
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_UPDATE_NS = 4000000;
  localparam int FRAME_UPDATE_CYC = FRAME_UPDATE_NS / CLK_PERIOD_NS;
  localparam logic [1:0] WAIT_STATES = 2'h1;
  typedef enum logic [2:0] {
    GBI_DISP_ALPHA = 3'b000,
    GBI_DISP_SEMI4 = 3'b001,
    GBI_DISP_SEMI6 = 3'b010,
    GBI_DISP_GFX = 3'b011
  } gbi_disp_e;
  typedef enum logic [1:0] {
    GBI_IDLE = 2'b00,
    GBI_HOLD = 2'b01,
    GBI_XFER = 2'b10
  } gbi_cyc_e;
endpackage : gbi_pkg

// *** verif/gbi_board_bench.sv ***
`timescale 1ns/10ps
module gbi_board_bench
  import gbi_pkg::*;
;
  logic i_clock, i_rst_b, i_power_on_clear_b, i_ext_clear_b, i_external_clear_jumper, i_bank_disable_switch;
  logic [7:0] i_bank_match_switch, i_port_address_switch, i_data_out, o_data_in, o_mode, q;
  logic [2:0] i_board_address_switch, o_graphics_mode, o_disp_kind;
  logic i_wait_insert_jumper, i_write_guard_jumper, i_field_only_option, i_field_pulse_b, i_row_restart_pulse_b;
  logic [15:0] i_addr;
  logic [3:0] strb;
  logic o_bus_owns_memory_b, o_ready, o_bank_led, o_color_set_select, o_semigraphic_set_select;
  int err_total, cmp_count, cycles, w, w0;
  bit ok;
  gbi_board i_gbi_board (.i_clock, .i_rst_b, .i_power_on_clear_b, .i_ext_clear_b, .i_external_clear_jumper,
    .i_addr, .i_data_out, .i_smemr(strb[0]), .i_mwrt(strb[1]), .i_sout(strb[2]), .i_sinp(strb[3]),
    .i_bank_match_switch, .i_port_address_switch, .i_board_address_switch, .i_bank_disable_switch,
    .i_wait_insert_jumper, .i_write_guard_jumper, .i_field_only_option, .i_field_pulse_b,
    .i_row_restart_pulse_b, .i_video_addr(13'h0000), .o_bus_owns_memory_b, .o_mem_addr(), .o_mem_we(),
    .o_mem_wdata(), .o_data_in, .o_data_in_oe(), .o_ready, .o_bank_led, .o_board_led(), .o_mode,
    .o_color_set_select, .o_semigraphic_set_select, .o_graphics_mode, .o_disp_kind);
  gbi_bus_master i_gbi_bus_master (.i_clock, .i_ready(o_ready), .i_owns_b(o_bus_owns_memory_b),
    .i_data_in(o_data_in), .o_addr(i_addr), .o_dout(i_data_out), .o_strb(strb));
  initial begin
    i_clock = 0;
    forever #5 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      summarize();
    end
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d);
    i_gbi_bus_master.cyc(k, a, d, q, w, ok);
  endtask : bus
  task automatic pulse_low(ref logic s);
    s = 0;
    repeat (2) @(posedge i_clock);
    #1 s = 1;
    repeat (3) @(posedge i_clock);
    #1;
  endtask : pulse_low
  task automatic t_modes();
    logic [7:0] m;
    for (int i = 0; i < 11; i++) begin
      m = i == 0 ? 8'h00 : i == 1 ? 8'h28 : i == 2 ? 8'h60 : i == 10 ? 8'h9f : 8'(8'h10 + i - 3);
      bus(4'h4, 16'h0001, m);
      chk(o_mode, m);
      chk({o_semigraphic_set_select, o_color_set_select, o_graphics_mode, o_disp_kind},
          {m[6], m[3], m[2:0], (i < 3 ? 3'(i) : 3'h3)});
    end
  endtask : t_modes
  task automatic t_bank();
    bus(4'h4, BANK_PORT_ADDR, 8'h06);
    chk(o_bank_led, 1);
    bus(4'h4, 16'h0041, 8'h00);
    chk(o_bank_led, 1);
    bus(4'h4, BANK_PORT_ADDR, 8'hfb);
    chk(o_bank_led, 0);
    bus(4'h1, 16'hc005, 8'h00);
    chk(ok, 0);
    bus(4'h4, BANK_PORT_ADDR, 8'h04);
    chk(o_bank_led, 1);
  endtask : t_bank
  task automatic t_mem();
    bus(4'h2, 16'hc005, 8'h5a);
    bus(4'h1, 16'hc005, 8'h00);
    chk(q, 8'h5a);
    bus(4'h1, 16'ha005, 8'h00);
    chk(ok, 0);
    bus(4'h8, 16'hc005, 8'h00);
    chk(ok, 0);
    bus(4'h2, 16'hd800, 8'ha5);
    bus(4'h1, 16'hd800, 8'h00);
    chk(q, 8'h00);
    w0 = w;
    i_wait_insert_jumper = 1;
    bus(4'h1, 16'hc005, 8'h00);
    chk(8'(w), 8'(w0 + 1));
    i_wait_insert_jumper = 0;
  endtask : t_mem
  task automatic t_wait(input logic field_only);
    i_field_pulse_b = 1;
    i_row_restart_pulse_b = 1;
    i_field_only_option = field_only;
    fork
      bus(4'h1, 16'hc005, 8'h00);
      begin
        repeat (20) @(posedge i_clock);
        #1 chk({o_ready, o_bus_owns_memory_b}, 8'h01);
        if (field_only) begin
          i_row_restart_pulse_b = 0;
          repeat (5) @(posedge i_clock);
          #1 chk(o_ready, 0);
          i_field_pulse_b = 0;
        end else i_row_restart_pulse_b = 0;
      end
    join
    chk(q, 8'h5a);
    i_field_pulse_b = 0;
    i_row_restart_pulse_b = 1;
    i_field_only_option = 0;
  endtask : t_wait
  task automatic t_guard();
    i_write_guard_jumper = 1;
    bus(4'h1, 16'hc005, 8'h00);
    chk(ok, 1);
    bus(4'h4, 16'h0001, 8'h10);
    bus(4'h1, 16'hc005, 8'h00);
    chk(ok, 0);
    i_write_guard_jumper = 0;
  endtask : t_guard
  task automatic t_clear();
    pulse_low(i_power_on_clear_b);
    chk(o_bank_led, 0);
    bus(4'h4, BANK_PORT_ADDR, 8'h04);
    pulse_low(i_ext_clear_b);
    chk(o_bank_led, 1);
    i_external_clear_jumper = 1;
    pulse_low(i_ext_clear_b);
    chk(o_bank_led, 0);
    i_bank_disable_switch = 1;
    bus(4'h1, 16'hc005, 8'h00);
    chk({o_bank_led, ok}, 8'h03);
  endtask : t_clear
  initial begin
    {i_rst_b, i_external_clear_jumper, i_bank_disable_switch, i_wait_insert_jumper} = 4'h0;
    {i_write_guard_jumper, i_field_only_option, i_field_pulse_b, i_row_restart_pulse_b} = 4'h1;
    {i_power_on_clear_b, i_ext_clear_b} = 2'h3;
    i_bank_match_switch = 8'h04;
    i_port_address_switch = 8'h01;
    i_board_address_switch = 3'h6;
    repeat (6) @(posedge i_clock);
    #1 i_rst_b = 1;
    repeat (3) @(posedge i_clock);
    #1 chk(o_mode, MODE_RESET);
    chk(o_bank_led, BANK_RESET);
    t_modes();
    t_bank();
    t_mem();
    t_wait(0);
    t_wait(1);
    t_guard();
    t_clear();
    summarize();
  end
endmodule : gbi_board_bench

// *** verif/gbi_bus_master.sv ***
`timescale 1ns/10ps
module gbi_bus_master (
  input wire logic i_clock,
  input wire logic i_ready,
  input wire logic i_owns_b,
  input wire logic [7:0] i_data_in,
  output logic [15:0] o_addr,
  output logic [7:0] o_dout,
  output logic [3:0] o_strb
);
  initial begin
    o_addr = 16'h0000;
    o_dout = 8'h00;
    o_strb = 4'h0;
  end
  // Strobe bits are read, write, output, input; all is held until two clocks after the memory is granted or the bound ends.
  task automatic cyc(input logic [3:0] k, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] q, output int w, output bit ok);
    w = 0;
    ok = 0;
    o_addr = a;
    o_dout = d;
    o_strb = k;
    for (int n = 0; n < (k[1:0] != 2'h0 ? 40 : 8) && !ok; n++) begin
      @(posedge i_clock);
      if (i_ready === 1'b0) w++;
      if (i_owns_b === 1'b0) ok = 1;
    end
    repeat (2) @(posedge i_clock);
    q = i_data_in;
    #1;
    o_strb = 4'h0;
    o_addr = ~a;
    o_dout = ~d;
    repeat (4) @(posedge i_clock);
    #1;
  endtask : cyc
endmodule : gbi_bus_master
